/* design/acr_chan_seq.v */
// Channel sequencer: steps through enabled channels in ascending order.
// Assumes i_advance is a one-cycle pulse from the converter core.
`timescale 1ns/10ps
module acr_chan_seq (
   input wire i_clk,
   input wire i_rst,
   input wire [3:0] i_enabled,
   input wire i_advance,
   output reg [1:0] o_chan,
   output wire o_valid
);
   reg [1:0] next_chan;
   reg found;
   integer k;
   // Next enabled channel above current, else wrap to lowest
   always @* begin
      next_chan = o_chan;
      found = 1'b0;
      for (k = 3; k >= 0; k = k - 1) begin
         if (i_enabled[k] && (k > o_chan)) begin
            next_chan = k[1:0];
            found = 1'b1;
         end
      end
      if (!found) begin
         for (k = 3; k >= 0; k = k - 1) begin
            if (i_enabled[k]) begin
               next_chan = k[1:0];
            end
         end
      end
   end
   assign o_valid = |i_enabled;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_chan <= 2'h0;
      end else if (i_advance || !i_enabled[o_chan]) begin
         o_chan <= next_chan;
      end
   end
endmodule // acr_chan_seq

/* design/acr_regbank.v */
// Configuration register bank of a multiplexed converter, reached over the serial link.
// Assumes a serial host, a converter core pulsing i_conv_done and supplying calibration.
//
// Notes on behaviour
// - Each channel register picks positive and negative input with five-bit pin codes.
// - Channel register holds enable in its top bit and a setup pick.
// - Enabled channels convert in ascending order, then wrap to the lowest.
// - Disabled channels are skipped by the sequencer.
// - Four setups, each with config, filter, gain and offset registers.
// - Any channel may use any setup; setups may be shared.
// - Bipolar setting: negative inputs allowed, offset binary coding.
// - Unipolar setting: positive inputs only, straight binary coding.
// - Reference source: internal, external pins, or analog supply.
// - Setup register enables input and reference buffers.
// - Filter register picks filter type, order and output rate.
// - Gain registers are 24-bit read/write with a factory value.
// - Gain replaced by full-scale calibration or host write.
// - Offset registers are 24-bit read/write, reset 0x800000.
// - Offset replaced by zero-scale calibration or host write.
// - Mode register: conversion mode, clock source, reference enable.
// - Interface mode: word length, checksum, status append, continuous read.
// - Reset: channel zero on, inputs zero and one, setup zero.
// - Every access starts with a command write, then returns to it.
// - Command low six bits address the register; one bit picks read.
`timescale 1ns/10ps
`include "acr_regs.vh"
module acr_regbank (
   input wire i_clk,
   input wire i_rst,
   input wire i_sclk,
   input wire i_cs_n,
   input wire i_din,
   output reg o_dout,
   output reg o_dout_oe,
   input wire i_cal_valid,
   input wire i_cal_full,
   input wire [1:0] i_cal_setup,
   input wire [23:0] i_cal_coef,
   input wire i_conv_done,
   output wire [1:0] o_chan,
   output wire o_seq_valid,
   output reg [4:0] o_plus_pin,
   output reg [4:0] o_minus_pin,
   output reg [1:0] o_setup,
   output reg o_bipolar,
   output reg [1:0] o_vref_source,
   output reg [3:0] o_buffers,
   output reg o_open_detect,
   output reg [15:0] o_filter_cfg,
   output reg [23:0] o_zero_trim,
   output reg [23:0] o_scale_trim,
   output reg [2:0] o_conv_mode,
   output reg [1:0] o_core_clock_source,
   output reg o_vref_enable,
   output reg [15:0] o_if_mode
);
   // ****************************************
   // States and local signals
   // ****************************************
   localparam ST_CMD = 1'b0;
   localparam ST_DATA = 1'b1;

   reg state_reg;
   reg [4:0] bit_cnt_reg;
   reg [4:0] len_reg;
   reg rd_reg;
   reg [5:0] addr_reg;
   reg [23:0] in_sh_reg;
   reg [23:0] out_sh_reg;
   reg [6:0] ones_cnt_reg;
   reg soft_rst;

   reg [15:0] ch_reg [0:3];
   reg [15:0] setup_reg [0:3];
   reg [15:0] filt_reg [0:3];
   reg [23:0] ztrim_reg [0:3];
   reg [23:0] strim_reg [0:3];
   reg [15:0] conv_mode_reg;
   reg [15:0] if_mode_reg;

   wire rise;
   wire fall;
   wire din;
   wire sel;
   wire [7:0] cmd_byte;
   wire cmd_done;
   wire data_done;
   wire wr_commit;
   reg [4:0] cmd_len;
   reg [23:0] rd_value;
   reg [23:0] rd_aligned;

   // ****************************************
   // Link front end
   // ****************************************
   acr_spi_link u_link (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_sclk(i_sclk),
      .i_cs_n(i_cs_n),
      .i_din(i_din),
      .o_rise(rise),
      .o_fall(fall),
      .o_din(din),
      .o_sel(sel)
   );

   // ****************************************
   // Command decode
   // ****************************************
   assign cmd_byte = {in_sh_reg[6:0], din};
   assign cmd_done = sel && rise && (state_reg == ST_CMD) &&
                     (bit_cnt_reg == `ACR_CMD_BITS - 5'd1);
   assign data_done = sel && rise && (state_reg == ST_DATA) &&
                      (bit_cnt_reg == len_reg - 5'd1);
   assign wr_commit = data_done && !rd_reg;

   // Data length from address group
   always @* begin
      case (cmd_byte[5:2])
         `ACR_GRP_ZTRIM: cmd_len = 5'd24;
         `ACR_GRP_STRIM: cmd_len = 5'd24;
         `ACR_GRP_CH: cmd_len = 5'd16;
         `ACR_GRP_SETUP: cmd_len = 5'd16;
         `ACR_GRP_FILT: cmd_len = 5'd16;
         default: begin
            if (cmd_byte[5:0] == `ACR_ADDR_CONV_MODE ||
                cmd_byte[5:0] == `ACR_ADDR_IF_MODE ||
                cmd_byte[5:0] == `ACR_ADDR_PART_CODE) begin
               cmd_len = 5'd16;
            end else begin
               cmd_len = 5'd8;
            end
         end
      endcase
   end

   // ****************************************
   // Read multiplexer
   // ****************************************
   // reserved read zero
   always @* begin
      case (cmd_byte[5:2])
         `ACR_GRP_CH: rd_value = {8'h00, ch_reg[cmd_byte[1:0]]};
         `ACR_GRP_SETUP: rd_value = {8'h00, setup_reg[cmd_byte[1:0]]};
         `ACR_GRP_FILT: rd_value = {8'h00, filt_reg[cmd_byte[1:0]]};
         `ACR_GRP_ZTRIM: rd_value = ztrim_reg[cmd_byte[1:0]];
         `ACR_GRP_STRIM: rd_value = strim_reg[cmd_byte[1:0]];
         default: begin
            case (cmd_byte[5:0])
               `ACR_ADDR_CONV_MODE: rd_value = {8'h00, conv_mode_reg};
               `ACR_ADDR_IF_MODE: rd_value = {8'h00, if_mode_reg};
               `ACR_ADDR_PART_CODE: rd_value = {8'h00, `ACR_PART_CODE};
               default: rd_value = 24'h000000;
            endcase
         end
      endcase
      // Left-justify so the first bit out is the MSB
      if (cmd_len == 5'd24) begin
         rd_aligned = rd_value;
      end else if (cmd_len == 5'd16) begin
         rd_aligned = {rd_value[15:0], 8'h00};
      end else begin
         rd_aligned = {rd_value[7:0], 16'h0000};
      end
   end

   // ****************************************
   // Serial transaction engine
   // ****************************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state_reg <= ST_CMD;
         bit_cnt_reg <= 5'd0;
         len_reg <= 5'd8;
         rd_reg <= 1'b0;
         addr_reg <= 6'h00;
         in_sh_reg <= 24'h000000;
         out_sh_reg <= 24'h000000;
         o_dout <= 1'b1;
         o_dout_oe <= 1'b0;
      end else if (!sel || soft_rst) begin
         state_reg <= ST_CMD;
         bit_cnt_reg <= 5'd0;
         rd_reg <= 1'b0;
         o_dout <= 1'b1;
         o_dout_oe <= sel;
      end else begin
         o_dout_oe <= 1'b1;
         if (rise) begin
            in_sh_reg <= {in_sh_reg[22:0], din};
            case (state_reg)
               ST_CMD: begin
                  if (cmd_done) begin
                     bit_cnt_reg <= 5'd0;
                     addr_reg <= cmd_byte[`ACR_CMD_ADDR_MSB:0];
                     rd_reg <= cmd_byte[`ACR_CMD_RD_BIT];
                     len_reg <= cmd_len;
                     out_sh_reg <= rd_aligned;
                     // Command with write-enable bit set is discarded
                     if (!cmd_byte[`ACR_CMD_WEN_BIT]) begin
                        state_reg <= ST_DATA;
                     end
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 5'd1;
                  end
               end
               ST_DATA: begin
                  if (data_done) begin
                     state_reg <= ST_CMD;
                     bit_cnt_reg <= 5'd0;
                     rd_reg <= 1'b0;
                  end else begin
                     bit_cnt_reg <= bit_cnt_reg + 5'd1;
                  end
               end
               default: begin
                  state_reg <= ST_CMD;
               end
            endcase
         end
         // Drive edge shifts read data out
         if (fall) begin
            if (state_reg == ST_DATA && rd_reg) begin
               o_dout <= out_sh_reg[23];
               out_sh_reg <= {out_sh_reg[22:0], 1'b0};
            end else begin
               o_dout <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // Serial reset on long run of ones
   // ****************************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         ones_cnt_reg <= 7'd0;
         soft_rst <= 1'b0;
      end else begin
         soft_rst <= 1'b0;
         if (sel && rise) begin
            if (!din) begin
               ones_cnt_reg <= 7'd0;
            end else if (ones_cnt_reg == `ACR_RESET_ONES - 7'd1) begin
               ones_cnt_reg <= 7'd0;
               soft_rst <= 1'b1;
            end else begin
               ones_cnt_reg <= ones_cnt_reg + 7'd1;
            end
         end
      end
   end

   // ****************************************
   // Global mode registers
   // ****************************************
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         conv_mode_reg <= `ACR_RST_CONV_MODE;
         if_mode_reg <= `ACR_RST_IF_MODE;
      end else if (soft_rst) begin
         conv_mode_reg <= `ACR_RST_CONV_MODE;
         if_mode_reg <= `ACR_RST_IF_MODE;
      end else if (wr_commit) begin
         if (addr_reg == `ACR_ADDR_CONV_MODE) begin
            conv_mode_reg <= {in_sh_reg[14:0], din} & `ACR_MASK_CONV_MODE;
         end
         if (addr_reg == `ACR_ADDR_IF_MODE) begin
            if_mode_reg <= {in_sh_reg[14:0], din} & `ACR_MASK_IF_MODE;
         end
      end
   end

   // ****************************************
   // Per-setup and per-channel registers
   // ****************************************
   genvar g;
   generate
      for (g = 0; g < 4; g = g + 1) begin : g_entry
         wire hit_ch = (addr_reg[5:2] == `ACR_GRP_CH) && (addr_reg[1:0] == g);
         wire hit_su = (addr_reg[5:2] == `ACR_GRP_SETUP) && (addr_reg[1:0] == g);
         wire hit_fi = (addr_reg[5:2] == `ACR_GRP_FILT) && (addr_reg[1:0] == g);
         wire hit_zt = (addr_reg[5:2] == `ACR_GRP_ZTRIM) && (addr_reg[1:0] == g);
         wire hit_st = (addr_reg[5:2] == `ACR_GRP_STRIM) && (addr_reg[1:0] == g);
         wire cal_hit = i_cal_valid && (i_cal_setup == g);
         wire [23:0] wdata = {in_sh_reg[22:0], din};
         always @(posedge i_clk or posedge i_rst) begin
            if (i_rst) begin
               ch_reg[g] <= (g == 0) ? `ACR_RST_CH0 : `ACR_RST_CHN;
               setup_reg[g] <= `ACR_RST_SETUP;
               filt_reg[g] <= `ACR_RST_FILT;
               ztrim_reg[g] <= `ACR_RST_ZTRIM;
               strim_reg[g] <= `ACR_RST_STRIM;
            end else if (soft_rst) begin
               ch_reg[g] <= (g == 0) ? `ACR_RST_CH0 : `ACR_RST_CHN;
               setup_reg[g] <= `ACR_RST_SETUP;
               filt_reg[g] <= `ACR_RST_FILT;
               ztrim_reg[g] <= `ACR_RST_ZTRIM;
               strim_reg[g] <= `ACR_RST_STRIM;
            end else begin
               if (wr_commit && hit_ch) begin
                  ch_reg[g] <= wdata[15:0] & `ACR_MASK_CH;
               end
               if (wr_commit && hit_su) begin
                  setup_reg[g] <= wdata[15:0] & `ACR_MASK_SETUP;
               end
               if (wr_commit && hit_fi) begin
                  filt_reg[g] <= wdata[15:0] & `ACR_MASK_FILT;
               end
               if (wr_commit && hit_zt) begin
                  ztrim_reg[g] <= wdata;
               end else if (cal_hit && !i_cal_full) begin
                  ztrim_reg[g] <= i_cal_coef;
               end
               if (wr_commit && hit_st) begin
                  strim_reg[g] <= wdata;
               end else if (cal_hit && i_cal_full) begin
                  strim_reg[g] <= i_cal_coef;
               end
            end
         end
      end
   endgenerate

   // ****************************************
   // Channel sequencer
   // ****************************************
   wire [3:0] chan_on = {ch_reg[3][`ACR_CH_ON_BIT], ch_reg[2][`ACR_CH_ON_BIT],
                         ch_reg[1][`ACR_CH_ON_BIT], ch_reg[0][`ACR_CH_ON_BIT]};

   acr_chan_seq u_seq (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_enabled(chan_on),
      .i_advance(i_conv_done),
      .o_chan(o_chan),
      .o_valid(o_seq_valid)
   );

   // ****************************************
   // Active configuration outputs
   // ****************************************
   wire [15:0] act_ch = ch_reg[o_chan];
   wire [1:0] act_su = act_ch[`ACR_CH_SETUP_LSB+1:`ACR_CH_SETUP_LSB];
   wire [15:0] act_cfg = setup_reg[act_su];

   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_plus_pin <= 5'h00;
         o_minus_pin <= 5'h01;
         o_setup <= 2'h0;
         o_bipolar <= 1'b1;
         o_vref_source <= 2'h0;
         o_buffers <= 4'h0;
         o_open_detect <= 1'b0;
         o_filter_cfg <= `ACR_RST_FILT;
         o_zero_trim <= `ACR_RST_ZTRIM;
         o_scale_trim <= `ACR_RST_STRIM;
         o_conv_mode <= 3'h0;
         o_core_clock_source <= 2'h0;
         o_vref_enable <= 1'b0;
         o_if_mode <= `ACR_RST_IF_MODE;
      end else begin
         o_plus_pin <= act_ch[`ACR_CH_PLUS_LSB+4:`ACR_CH_PLUS_LSB];
         o_minus_pin <= act_ch[4:0];
         o_setup <= act_su;
         o_bipolar <= act_cfg[`ACR_SU_POLARITY_BIT];
         o_vref_source <= act_cfg[`ACR_SU_VREF_LSB+1:`ACR_SU_VREF_LSB];
         o_buffers <= act_cfg[`ACR_SU_BUF_LSB+3:`ACR_SU_BUF_LSB];
         o_open_detect <= act_cfg[`ACR_SU_OPEN_BIT];
         o_filter_cfg <= filt_reg[act_su];
         o_zero_trim <= ztrim_reg[act_su];
         o_scale_trim <= strim_reg[act_su];
         o_conv_mode <= conv_mode_reg[`ACR_CM_MODE_LSB+2:`ACR_CM_MODE_LSB];
         o_core_clock_source <= conv_mode_reg[`ACR_CM_CLKSRC_LSB+1:`ACR_CM_CLKSRC_LSB];
         o_vref_enable <= conv_mode_reg[`ACR_CM_VREF_EN_BIT];
         o_if_mode <= if_mode_reg;
      end
   end
endmodule // acr_regbank

/* design/acr_spi_link.v */
// Serial link front end: synchronises the link pins and finds clock edges.
// Assumes the serial clock is far slower than i_clk and idles high.
`timescale 1ns/10ps
module acr_spi_link (
   input wire i_clk,
   input wire i_rst,
   input wire i_sclk,
   input wire i_cs_n,
   input wire i_din,
   output reg o_rise,
   output reg o_fall,
   output wire o_din,
   output wire o_sel
);
   // ****************************************
   // Two-stage synchronisers
   // ****************************************
   reg [2:0] s1_reg;
   reg [2:0] s2_reg;
   reg sclk_old_reg;
   always @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         s1_reg <= 3'h7;
         s2_reg <= 3'h7;
         sclk_old_reg <= 1'b1;
         o_rise <= 1'b0;
         o_fall <= 1'b0;
      end else begin
         s1_reg <= {i_sclk, i_cs_n, i_din};
         s2_reg <= s1_reg;
         sclk_old_reg <= s2_reg[2];
         o_rise <= s2_reg[2] & ~sclk_old_reg;
         o_fall <= ~s2_reg[2] & sclk_old_reg;
      end
   end
   assign o_din = s2_reg[0];
   assign o_sel = ~s2_reg[1];
endmodule // acr_spi_link

/* pkg/acr_regs.vh */
// Register map, field positions, reset values and counts for the converter setup bank.
// Assumes inclusion by the design and bench files; holds definitions alone.
`ifndef ACR_REGS_VH
`define ACR_REGS_VH

// ****************************************
// Register offsets
// ****************************************
`define ACR_ADDR_CMD 6'h00
`define ACR_ADDR_CONV_MODE 6'h01
`define ACR_ADDR_IF_MODE 6'h02
`define ACR_ADDR_PART_CODE 6'h07
`define ACR_ADDR_CH0 6'h10
`define ACR_ADDR_SETUP0 6'h20
`define ACR_ADDR_FILT0 6'h28
`define ACR_ADDR_ZTRIM0 6'h30
`define ACR_ADDR_STRIM0 6'h38
// Groups of four: address bits 5:2
`define ACR_GRP_CH 4'h4
`define ACR_GRP_SETUP 4'h8
`define ACR_GRP_FILT 4'hA
`define ACR_GRP_ZTRIM 4'hC
`define ACR_GRP_STRIM 4'hE

// ****************************************
// Command byte fields
// ****************************************
`define ACR_CMD_WEN_BIT 7
`define ACR_CMD_RD_BIT 6
`define ACR_CMD_ADDR_MSB 5

// ****************************************
// Writable bit masks
// ****************************************
`define ACR_MASK_CH 16'hB3FF
`define ACR_MASK_SETUP 16'h1FB0
`define ACR_MASK_FILT 16'h8F7F
`define ACR_MASK_CONV_MODE 16'hE77C
`define ACR_MASK_IF_MODE 16'h19ED

// ****************************************
// Field positions
// ****************************************
`define ACR_CH_ON_BIT 15
`define ACR_CH_SETUP_LSB 12
`define ACR_CH_PLUS_LSB 5
`define ACR_SU_POLARITY_BIT 12
`define ACR_SU_BUF_LSB 8
`define ACR_SU_OPEN_BIT 7
`define ACR_SU_VREF_LSB 4
`define ACR_CM_VREF_EN_BIT 15
`define ACR_CM_MODE_LSB 4
`define ACR_CM_CLKSRC_LSB 2

// ****************************************
// Reset values
// ****************************************
`define ACR_RST_CH0 16'h8001
`define ACR_RST_CHN 16'h0001
`define ACR_RST_SETUP 16'h1000
`define ACR_RST_FILT 16'h0500
`define ACR_RST_CONV_MODE 16'h0000
`define ACR_RST_IF_MODE 16'h0000
`define ACR_RST_ZTRIM 24'h800000
`define ACR_RST_STRIM 24'h555550
`define ACR_PART_CODE 16'h0AB0 // Arbitrary part code

// ****************************************
// Counts
// ****************************************
`define ACR_CMD_BITS 5'd8
`define ACR_RESET_ONES 7'd64

`endif

/* test/acr_host_model.sv */
// Host side of the serial link: mode-3 frames, MSB first.
// Assumes the bank clock; link edges move on its falling edges.
`timescale 1ns/10ps
module acr_host_model (
   input wire i_clk,
   input wire i_dout,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_din
);
   initial begin
      o_sclk = 1'b1;
      o_cs_n = 1'b1;
      o_din = 1'b1;
   end
   task automatic frame(input logic [63:0] v, input int n, output logic [63:0] r);
      r = '0;
      @(negedge i_clk);
      o_cs_n = 1'b0;
      repeat (4) @(negedge i_clk);
      for (int i = n - 1; i >= 0; i--) begin
         o_sclk = 1'b0;
         o_din = v[i];
         repeat (5) @(negedge i_clk);
         o_sclk = 1'b1;
         r = {r[62:0], i_dout};
         repeat (3) @(negedge i_clk);
      end
      repeat (3) @(negedge i_clk);
      o_cs_n = 1'b1;
      o_din = ~o_din;
      repeat (4) @(negedge i_clk);
   endtask
endmodule // acr_host_model

/* test/acr_regbank_monitor.sv */
// Port checker for the converter setup register bank.
// Assumes acr_regs.vh on the include path; bound to acr_regbank.
`timescale 1ns/10ps
`include "acr_regs.vh"
module acr_regbank_monitor (
   input wire i_clk,
   input wire i_rst,
   input wire i_cs_n,
   input wire o_dout,
   input wire o_dout_oe,
   input wire i_cal_valid,
   input wire i_cal_full,
   input wire [1:0] i_cal_setup,
   input wire [23:0] i_cal_coef,
   input wire i_conv_done,
   input wire [1:0] o_chan,
   input wire [4:0] o_plus_pin,
   input wire [4:0] o_minus_pin,
   input wire [1:0] o_setup,
   input wire [23:0] o_zero_trim,
   input wire [23:0] o_scale_trim,
   input wire [2:0] o_conv_mode,
   input wire [15:0] o_if_mode
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_rst);
   a_oe_drops: assert property (i_cs_n [*4] |=> !o_dout_oe)
      else $error("drive stays on");
   a_oe_rise: assert property ($rose(o_dout_oe) |-> !i_cs_n && !$past(i_cs_n))
      else $error("drive without select");
   a_dout_idle: assert property (!o_dout_oe |-> o_dout)
      else $error("data line not high");
   a_reset_channel: assert property ($fell(i_rst) |-> o_chan == 2'd0 &&
      o_setup == 2'd0 && o_plus_pin == 5'd0 && o_minus_pin == 5'd1)
      else $error("reset channel wrong");
   a_reset_trims: assert property ($fell(i_rst) |-> o_zero_trim == `ACR_RST_ZTRIM &&
      o_scale_trim == `ACR_RST_STRIM)
      else $error("reset trims wrong");
   a_cal_zero: assert property (i_cal_valid && !i_cal_full && i_cal_setup == o_setup &&
      i_cs_n && !i_conv_done |-> ##2 o_zero_trim == $past(i_cal_coef, 2))
      else $error("offset missed");
   a_cal_scale: assert property (i_cal_valid && i_cal_full && i_cal_setup == o_setup &&
      i_cs_n && !i_conv_done |-> ##2 o_scale_trim == $past(i_cal_coef, 2))
      else $error("gain missed");
   a_mode_quiet: assert property (i_cs_n [*6] |=> $stable(o_conv_mode) && $stable(o_if_mode))
      else $error("mode moved idle");
   c_cal: cover property (i_cal_valid && i_cal_full);
   c_select: cover property ($rose(o_dout_oe));
   c_advance: cover property (i_conv_done && o_chan == 2'd2);
endmodule // acr_regbank_monitor
bind acr_regbank acr_regbank_monitor acr_regbank_monitor_inst (.i_clk(i_clk), .i_rst(i_rst),
   .i_cs_n(i_cs_n), .o_dout(o_dout), .o_dout_oe(o_dout_oe), .i_cal_valid(i_cal_valid),
   .i_cal_full(i_cal_full), .i_cal_setup(i_cal_setup), .i_cal_coef(i_cal_coef),
   .i_conv_done(i_conv_done), .o_chan(o_chan), .o_plus_pin(o_plus_pin),
   .o_minus_pin(o_minus_pin), .o_setup(o_setup), .o_zero_trim(o_zero_trim),
   .o_scale_trim(o_scale_trim), .o_conv_mode(o_conv_mode), .o_if_mode(o_if_mode));

/* test/test_adc_channel_setup_registers.sv */
// Bench: drives the bank through the host model and checks its ports.
// Assumes acr_regs.vh on the include path.
`timescale 1ns/10ps
`include "acr_regs.vh"
module test_adc_channel_setup_registers;
   logic i_clk = 1'b0;
   logic i_rst = 1'b1;
   logic cal_v = 1'b0;
   logic cal_f = 1'b0;
   logic [1:0] cal_s = 2'd0;
   logic [23:0] cal_c = 24'h0;
   logic done = 1'b0;
   wire sclk, cs_n, din, dout, oe, sv, bip, od, ve;
   wire [1:0] chan, setup, vsrc, csrc;
   wire [4:0] pp, mp;
   wire [3:0] bufs;
   wire [2:0] cm;
   wire [15:0] filt, ifm;
   wire [23:0] zt, st;
   wire line = oe ? dout : 1'b1;
   int n_fail = 0;
   int comparisons = 0;
   int cycles = 0;
   int c;
   logic [63:0] r;
   logic [23:0] d, q;
   logic [5:0] ra [9] = '{6'h01, 6'h02, 6'h07, 6'h10, 6'h11, 6'h20, 6'h28, 6'h30, 6'h38};
   logic [23:0] rv [9] = '{24'h0, 24'h0, {8'h00, `ACR_PART_CODE}, 24'h8001, 24'h0001,
      24'h1000, 24'h0500, 24'h800000, `ACR_RST_STRIM};
   logic [5:0] wa [10] = '{6'h01, 6'h02, 6'h11, 6'h13, 6'h22, 6'h2B, 6'h31, 6'h3A, 6'h05, 6'h3E};
   acr_regbank acr_regbank_inst (.i_clk(i_clk), .i_rst(i_rst), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_din(din), .o_dout(dout), .o_dout_oe(oe), .i_cal_valid(cal_v), .i_cal_full(cal_f),
      .i_cal_setup(cal_s), .i_cal_coef(cal_c), .i_conv_done(done), .o_chan(chan),
      .o_seq_valid(sv), .o_plus_pin(pp), .o_minus_pin(mp), .o_setup(setup), .o_bipolar(bip),
      .o_vref_source(vsrc), .o_buffers(bufs), .o_open_detect(od), .o_filter_cfg(filt),
      .o_zero_trim(zt), .o_scale_trim(st), .o_conv_mode(cm), .o_core_clock_source(csrc),
      .o_vref_enable(ve), .o_if_mode(ifm));
   acr_host_model acr_host_model_inst (.i_clk(i_clk), .i_dout(line), .o_sclk(sclk),
      .o_cs_n(cs_n), .o_din(din));
   always #25 i_clk = ~i_clk;
   function automatic int nb(input logic [5:0] a);
      if (a[5:2] == `ACR_GRP_ZTRIM || a[5:2] == `ACR_GRP_STRIM) return 24;
      if (a == 6'h01 || a == 6'h02 || a == 6'h07 || a[5:2] == `ACR_GRP_CH) return 16;
      if (a[5:2] == `ACR_GRP_SETUP || a[5:2] == `ACR_GRP_FILT) return 16;
      return 8;
   endfunction
   function automatic logic [23:0] mask(input logic [5:0] a);
      if (a[5:2] == `ACR_GRP_CH) return {8'h00, `ACR_MASK_CH};
      if (a[5:2] == `ACR_GRP_SETUP) return {8'h00, `ACR_MASK_SETUP};
      if (a[5:2] == `ACR_GRP_FILT) return {8'h00, `ACR_MASK_FILT};
      if (nb(a) == 24) return 24'hFFFFFF;
      if (a == 6'h01) return {8'h00, `ACR_MASK_CONV_MODE};
      if (a == 6'h02) return {8'h00, `ACR_MASK_IF_MODE};
      return 24'h0;
   endfunction
   function automatic int next_chan(input int cur, input logic [3:0] en);
      for (int i = 1; i <= 4; i++)
         if (en[(cur + i) % 4]) return (cur + i) % 4;
      return cur;
   endfunction
   task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
      comparisons++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic wr(input logic [5:0] a, input logic [23:0] v);
      acr_host_model_inst.frame(({56'h0, 2'b00, a} << nb(a)) | {40'h0, v}, 8 + nb(a), r);
   endtask
   task automatic rd(input logic [5:0] a);
      acr_host_model_inst.frame({56'h0, 2'b01, a} << nb(a), 8 + nb(a), r);
      q = r[23:0] & ((24'h1 << nb(a)) - 24'h1);
   endtask
   task automatic wrap_up;
      $display("comparisons %0d n_fail %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 40000) begin
         n_fail++;
         wrap_up();
      end
   end
   initial begin
      void'($urandom(32'hcbe29bd9));
      repeat (20) @(negedge i_clk);
      i_rst = 1'b0;
      repeat (2) @(negedge i_clk);
      check("reset view", {10'h0, 2'd0, 2'd0, 5'd0, 5'd1}, {10'h0, chan, setup, pp, mp});
      check("reset bipolar", 24'h1, {23'h0, bip});
      check("reset filt", {7'h0, 1'b1, `ACR_RST_FILT}, {7'h0, sv, filt});
      foreach (ra[k]) begin
         rd(ra[k]);
         check("reset value", rv[k], q);
      end
      foreach (wa[k]) begin
         d = $urandom() & ((24'h1 << nb(wa[k])) - 24'h1);
         wr(wa[k], d);
         rd(wa[k]);
         check("readback", d & mask(wa[k]), q);
         if (wa[k] == 6'h01)
            check("mode", {18'h0, d[15], d[3:2], d[6:4]}, {18'h0, ve, csrc, cm});
         if (wa[k] == 6'h02)
            check("if mode", d & mask(6'h02), {8'h00, ifm});
      end
      wr(6'h12, 24'h9043);
      wr(6'h13, 24'hA064);
      wr(6'h11, 24'h0001);
      wr(6'h21, 24'h03A0);
      c = 0;
      repeat (3) begin
         check("chan", c, {22'h0, chan});
         if (c == 2)
            check("ch2 view", {4'h0, 1'b1, 12'h443, 7'h0E},
               {4'h0, od, setup, pp, mp, bip, bufs, vsrc});
         @(negedge i_clk);
         done = 1'b1;
         @(negedge i_clk);
         done = 1'b0;
         repeat (3) @(negedge i_clk);
         c = next_chan(c, 4'b1101);
      end
      wr(6'h10, 24'h0001);
      check("skip", 24'h2, {22'h0, chan});
      acr_host_model_inst.frame({40'h0, 8'h90, 16'h8001}, 24, r);
      rd(6'h10);
      check("refused", 24'h0001, q);
      d = $urandom();
      @(negedge i_clk);
      cal_v = 1'b1;
      cal_s = 2'd1;
      cal_c = d;
      @(negedge i_clk);
      cal_f = 1'b1;
      cal_c = ~d;
      @(negedge i_clk);
      cal_v = 1'b0;
      repeat (2) @(negedge i_clk);
      check("zero trim", d, zt);
      check("scale trim", ~d, st);
      rd(6'h39);
      check("scale read", ~d, q);
      acr_host_model_inst.frame({64{1'b1}}, 64, r);
      rd(6'h12);
      check("soft reset", 24'h0001, q);
      check("soft chan", 24'h0, {22'h0, chan});
      wrap_up();
   end
endmodule // test_adc_channel_setup_registers
